//--- design/mwc_host.sv
// Host controller that frames memory write, fill, execute, call and reset
// Notes on behaviour
// - Send exactly the byte count as data
// - Store frame: opcode 04, three parameters, data
// - Fill params: address, count, word; no data
// - Fill start word aligned, count multiple four
// - Wide flash: 64-bit alignment, count multiple eight
// - Replicate 8 or 16 bit fill values
// - Flash sectors erased before write or fill
// - Flash targets need page aligned start
// - Execute params: jump, argument, stack pointer
// - Call address must be flash or RAM
// - Reset: opcode 0b, no params, length four
// - Wait five seconds after reset for application
`timescale 1ns/100ps
module mwc_host
    import mwc_pkg::*;
#(
    parameter int PAGE_BYTES = 256, // Flash page size, power of two
    parameter bit WIDE_FLASH = 1'b0, // Part uses the wider flash variant
    parameter logic [31:0] FLASH_LO = 32'h0000_0000,
    parameter logic [31:0] FLASH_HI = 32'h0fff_ffff,
    parameter logic [31:0] RAM_LO = 32'h2000_0000,
    parameter logic [31:0] RAM_HI = 32'h2fff_ffff,
    parameter longint APP_WAIT_CYC = MWC_APP_WAIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // User request
    input wire mwc_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    // Data bytes for the store data phase
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // Outcome
    output mwc_rsp_t rsp,
    output logic done,
    // Byte stream toward the framing link
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    // Byte stream from the framing link
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic rx_ready
);
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_CHECK = 3'h1, S_CRC = 3'h2, S_SEND = 3'h3,
        S_GATHER = 3'h4, S_RX = 3'h5, S_WAIT = 3'h6, S_DONE = 3'h7
    } mwc_state_t;

    localparam logic [31:0] PAGE_M = 32'(PAGE_BYTES - 1);
    localparam logic [31:0] FILL_M = WIDE_FLASH ? 32'h7 : 32'h3;

    mwc_state_t state_q; // Sequencer state
    mwc_req_t req_q; // Captured request
    logic [7:0] fr_q [MWC_FRAME_MAX]; // Frame under construction
    logic [4:0] flen_q; // Frame length in bytes
    logic [4:0] idx_q; // Walk index for CRC and send
    logic [15:0] crc_q; // Running CRC
    logic [31:0] remain_q; // Data bytes still owed
    logic [2:0] gcnt_q; // Bytes gathered into this data packet
    logic data_q; // Command owns a data phase
    logic [31:0] wait_q; // Application start wait
    logic [7:0] buf_q [2]; // Two-entry data buffer
    logic wp_q, rp_q; // Buffer pointers
    logic [1:0] cnt_q; // Buffer occupancy
    logic [15:0] ridx_q, rlen_q; // Reply byte index and length
    logic [31:0] rstat_q; // Reply status word
    logic rfin_q; // Reply complete pulse
    logic bad; // Request fails host checks
    logic [31:0] pat; // Replicated fill pattern
    logic pop; // Buffer drain strobe
    logic [1:0] cnt_d;

    // CRC16 over one byte, MSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ((r << 1) ^ MWC_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Pattern replication and host side preconditions
    always_comb
    begin
        unique case (req_q.fill_w)
            MWC_W8: pat = {4{req_q.word[7:0]}};
            MWC_W16: pat = {2{req_q.word[15:0]}};
            default: pat = req_q.word;
        endcase
        bad = 1'b0;
        // Flash targets: erased and page aligned; a RAM store takes any start
        if ((req_q.kind == MWC_K_STORE || req_q.kind == MWC_K_FILL)
            && req_q.to_flash)
            bad = !req_q.erased
                || ((req_q.base_addr_param & PAGE_M) != 32'h0);
        if (req_q.kind == MWC_K_FILL
            && (((req_q.length_param & FILL_M) != 32'h0)
                || ((req_q.base_addr_param & FILL_M) != 32'h0)))
            bad = 1'b1;
        if (req_q.kind == MWC_K_CALL
            && !((req_q.base_addr_param >= FLASH_LO
                  && req_q.base_addr_param <= FLASH_HI)
                 || (req_q.base_addr_param >= RAM_LO
                     && req_q.base_addr_param <= RAM_HI)))
            bad = 1'b1;
    end

    // Buffer drains one byte a cycle while gathering a packet
    assign pop = (state_q == S_GATHER) && (cnt_q != 2'h0)
                 && (remain_q != 32'h0) && (gcnt_q != 3'h4);
    assign cnt_d = cnt_q + 2'(wr_valid && wr_ready) - 2'(pop);

    // Two-entry buffer; ready drops when both slots hold a byte
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            wr_ready <= 1'b0;
            buf_q[0] <= 8'h00;
            buf_q[1] <= 8'h00;
        end
        else
        begin
            if (wr_valid && wr_ready)
            begin
                buf_q[wp_q] <= wr_data;
                wp_q <= !wp_q;
            end
            if (pop)
                rp_q <= !rp_q;
            cnt_q <= cnt_d;
            wr_ready <= (cnt_d != 2'h2);
        end
    end

    // Sequencer, frame builder and transmitter
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= S_IDLE;
            req_q <= '0;
            for (int i = 0; i < MWC_FRAME_MAX; i++)
                fr_q[i] <= 8'h00;
            flen_q <= 5'h00;
            idx_q <= 5'h00;
            crc_q <= 16'h0000;
            remain_q <= 32'h0;
            gcnt_q <= 3'h0;
            data_q <= 1'b0;
            wait_q <= 32'h0;
            req_ready <= 1'b0;
            done <= 1'b0;
            rsp <= '0;
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state_q)
                S_IDLE:
                begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready)
                    begin
                        req_q <= req;
                        req_ready <= 1'b0;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK:
                begin
                    // Header and parameter bytes, little endian
                    fr_q[0] <= MWC_START;
                    fr_q[1] <= MWC_FRAME_CMD;
                    fr_q[7] <= MWC_FLAG_NONE;
                    fr_q[8] <= 8'h00;
                    fr_q[9] <= MWC_ARGS3;
                    fr_q[3] <= 8'h00;
                    fr_q[2] <= 8'(MWC_LEN_3ARG - MWC_PREFIX);
                    flen_q <= MWC_LEN_3ARG;
                    data_q <= 1'b0;
                    remain_q <= req_q.length_param;
                    for (int b = 0; b < 4; b++)
                    begin
                        fr_q[10 + b] <= req_q.base_addr_param[8*b +: 8];
                        unique case (req_q.kind)
                            MWC_K_STORE, MWC_K_FILL:
                                fr_q[14 + b] <= req_q.length_param[8*b +: 8];
                            default:
                                fr_q[14 + b] <= req_q.word[8*b +: 8];
                        endcase
                        unique case (req_q.kind)
                            MWC_K_STORE:
                                fr_q[18 + b] <= req_q.mem_id[8*b +: 8];
                            MWC_K_FILL:
                                fr_q[18 + b] <= pat[8*b +: 8];
                            default: // Call sends it, device ignores it
                                fr_q[18 + b] <= req_q.stack[8*b +: 8];
                        endcase
                    end
                    unique case (req_q.kind)
                        MWC_K_STORE:
                        begin
                            fr_q[6] <= MWC_OP_STORE;
                            fr_q[7] <= MWC_FLAG_DATA;
                            data_q <= 1'b1;
                        end
                        MWC_K_FILL: fr_q[6] <= MWC_OP_FILL;
                        MWC_K_EXEC: fr_q[6] <= MWC_OP_EXEC;
                        MWC_K_CALL: fr_q[6] <= MWC_OP_CALL;
                        default:
                        begin
                            fr_q[6] <= MWC_OP_RESET;
                            fr_q[9] <= MWC_ARGS0;
                            fr_q[2] <= 8'(MWC_LEN_NOARG - MWC_PREFIX);
                            flen_q <= MWC_LEN_NOARG;
                        end
                    endcase
                    idx_q <= 5'h00;
                    crc_q <= 16'h0000;
                    // Refused requests never reach the link
                    if (bad)
                    begin
                        rsp <= '{local_reject: 1'b1, status: MWC_BAD_ARG};
                        state_q <= S_DONE;
                    end
                    else
                        state_q <= S_CRC;
                end
                S_CRC:
                begin
                    // CRC spans the frame except its own two bytes
                    if (idx_q == flen_q)
                    begin
                        fr_q[MWC_CRC_LO] <= crc_q[7:0];
                        fr_q[MWC_CRC_HI] <= crc_q[15:8];
                        idx_q <= 5'h00;
                        state_q <= S_SEND;
                    end
                    else
                    begin
                        if (idx_q != MWC_CRC_LO && idx_q != MWC_CRC_HI)
                            crc_q <= crc_step(crc_q, fr_q[idx_q]);
                        idx_q <= idx_q + 5'h01;
                    end
                end
                S_SEND:
                begin
                    if (!tx_valid || tx_ready)
                    begin
                        if (idx_q != flen_q)
                        begin
                            tx_byte <= fr_q[idx_q];
                            tx_valid <= 1'b1;
                            idx_q <= idx_q + 5'h01;
                        end
                        else
                        begin
                            tx_valid <= 1'b0;
                            fr_q[0] <= MWC_START;
                            fr_q[1] <= MWC_FRAME_DATA;
                            gcnt_q <= 3'h0;
                            // Keep sending data until the count is met
                            if (data_q && remain_q != 32'h0)
                                state_q <= S_GATHER;
                            else
                                state_q <= S_RX;
                        end
                    end
                end
                S_GATHER:
                begin
                    if (pop)
                    begin
                        fr_q[5'(MWC_PREFIX + 5'(gcnt_q))] <= buf_q[rp_q];
                        gcnt_q <= gcnt_q + 3'h1;
                        remain_q <= remain_q - 32'h1;
                    end
                    else if (gcnt_q == 3'h4
                             || (remain_q == 32'h0 && gcnt_q != 3'h0))
                    begin
                        fr_q[2] <= 8'(gcnt_q);
                        fr_q[3] <= 8'h00;
                        flen_q <= MWC_PREFIX + 5'(gcnt_q);
                        idx_q <= 5'h00;
                        crc_q <= 16'h0000;
                        state_q <= S_CRC;
                    end
                end
                S_RX:
                begin
                    // Reply comes once after data, or alone
                    if (rfin_q)
                    begin
                        rsp <= '{local_reject: 1'b0, status: rstat_q};
                        wait_q <= 32'(APP_WAIT_CYC - 1);
                        if (req_q.kind == MWC_K_RESET
                            && rstat_q == MWC_SUCCESS)
                            state_q <= S_WAIT;
                        else
                            state_q <= S_DONE;
                    end
                end
                S_WAIT:
                begin
                    // Application needs this long to come up
                    if (wait_q == 32'h0)
                        state_q <= S_DONE;
                    else
                        wait_q <= wait_q - 32'h1;
                end
                S_DONE:
                begin
                    done <= 1'b1;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Reply parser; framing acks and stray bytes are skipped
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ridx_q <= 16'h0;
            rlen_q <= 16'h0;
            rstat_q <= 32'h0;
            rfin_q <= 1'b0;
            rx_ready <= 1'b0;
        end
        else
        begin
            rfin_q <= 1'b0;
            rx_ready <= (state_q == S_RX) && !rfin_q;
            if (rx_valid && rx_ready)
            begin
                ridx_q <= ridx_q + 16'h1;
                if (ridx_q == 16'h0 && rx_byte != MWC_START)
                    ridx_q <= 16'h0;
                if (ridx_q == 16'h1 && rx_byte != MWC_FRAME_CMD)
                    ridx_q <= 16'h0;
                if (ridx_q == 16'h2)
                    rlen_q[7:0] <= rx_byte;
                if (ridx_q == 16'h3)
                    rlen_q[15:8] <= rx_byte;
                for (int b = 0; b < 4; b++)
                begin
                    if (ridx_q == MWC_RSP_STAT + 16'(b))
                        rstat_q[8*b +: 8] <= rx_byte;
                end
                if (ridx_q > MWC_RSP_LAST && ridx_q == MWC_RSP_LAST + rlen_q)
                begin
                    ridx_q <= 16'h0;
                    rfin_q <= 1'b1;
                    rx_ready <= 1'b0;
                end
            end
        end
    end

    // Held byte stays put while the link stalls
    a_tx_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("tx byte changed under stall");
    // Buffer never over-fills and ready tracks room
    a_buf_room: assert property (@(posedge ref_clk) disable iff (!nrst)
        cnt_q == 2'h2 |-> !wr_ready)
        else $error("buffer full but ready high");
    // A frame always opens with the start byte
    a_frame_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_SEND && idx_q == 5'h00 && (!tx_valid || tx_ready)
        |=> tx_byte == MWC_START)
        else $error("frame did not open with start byte");
    // Data packets carry one to four bytes of the store payload
    a_data_exact: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_CRC && data_q && fr_q[1] == MWC_FRAME_DATA
        |-> fr_q[2] != 8'h00 && fr_q[2] <= 8'(MWC_DWORD))
        else $error("data packet size out of range");
    a_data_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_RX && $past(state_q) == S_SEND && data_q
        |-> remain_q == 32'h0)
        else $error("data phase left bytes unsent");
    // Reset frame is four payload bytes
    a_reset_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_CRC && req_q.kind == MWC_K_RESET && !data_q
        |-> flen_q == MWC_LEN_NOARG && fr_q[2] == 8'h04)
        else $error("reset frame length wrong");
    // Refused requests report bad argument without touching the link
    sequence s_refuse;
        state_q == S_CHECK && bad;
    endsequence
    a_refuse_rsp: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_refuse |=> state_q == S_DONE ##1 done && rsp.local_reject
        && rsp.status == MWC_BAD_ARG && !tx_valid)
        else $error("refusal not reported");
    // Fill word goes out replicated for byte patterns
    a_fill_pat: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_CHECK && !bad && req_q.kind == MWC_K_FILL
        && req_q.fill_w == MWC_W8 |=> fr_q[18] == fr_q[21]
        && fr_q[19] == fr_q[20] && fr_q[18] == fr_q[19])
        else $error("fill pattern not replicated");
    // Success after reset holds off done for the next two cycles
    a_reset_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == S_RX && rfin_q && req_q.kind == MWC_K_RESET
        && rstat_q == MWC_SUCCESS |=> !done [*2])
        else $error("done came before boot wait");
    // Done is a single-cycle pulse
    a_done_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        done |=> !done)
        else $error("done held over one cycle");
endmodule // mwc_host

//--- design/mwc_pkg.sv
// Package: constants and carriers for the memory command host controller
package mwc_pkg;
    // Framing bytes
    localparam logic [7:0] MWC_START = 8'h5a; // Frame start byte
    localparam logic [7:0] MWC_FRAME_CMD = 8'ha4; // command_frame_type
    localparam logic [7:0] MWC_FRAME_DATA = 8'ha5; // Data packet type
    // Opcodes carried in opcode_field
    localparam logic [7:0] MWC_OP_STORE = 8'h04; // store_block_cmd
    localparam logic [7:0] MWC_OP_FILL = 8'h05; // pattern_fill_cmd
    localparam logic [7:0] MWC_OP_RESET = 8'h0b; // Chip reset
    localparam logic [7:0] MWC_OP_EXEC = 8'h09; // Execute (jump)
    localparam logic [7:0] MWC_OP_CALL = 8'h0a; // Call function
    // Flags byte: store announces its data phase
    localparam logic [7:0] MWC_FLAG_DATA = 8'h01;
    localparam logic [7:0] MWC_FLAG_NONE = 8'h00;
    // arg_count_field values
    localparam logic [7:0] MWC_ARGS3 = 8'h03;
    localparam logic [7:0] MWC_ARGS0 = 8'h00;
    // Frame geometry, in bytes
    localparam logic [4:0] MWC_PREFIX = 5'h06; // Start, type, len, crc
    localparam logic [4:0] MWC_CRC_LO = 5'h04; // CRC low byte slot
    localparam logic [4:0] MWC_CRC_HI = 5'h05; // CRC high byte slot
    localparam logic [4:0] MWC_PARAM0 = 5'h0a; // First parameter byte
    localparam logic [4:0] MWC_LEN_NOARG = 5'h0a; // Frame with no params
    localparam logic [4:0] MWC_LEN_3ARG = 5'h16; // Frame with three params
    localparam logic [4:0] MWC_DWORD = 5'h04; // Data bytes per packet
    localparam int MWC_FRAME_MAX = 22; // Largest frame held
    // Response: status word sits after the four header bytes
    localparam logic [15:0] MWC_RSP_STAT = 16'h000a;
    localparam logic [15:0] MWC_RSP_LAST = 16'h0005; // Prefix minus one
    localparam logic [15:0] MWC_CRC_POLY = 16'h1021;
    // Status codes
    localparam logic [31:0] MWC_SUCCESS = 32'h0000_0000; // success_status
    localparam logic [31:0] MWC_BAD_ARG = 32'h0000_0069; // bad_argument_status
    // Wait after a reset that boots the application
    localparam longint MWC_CLK_HZ = 200_000_000;
    localparam longint MWC_APP_WAIT_S = 5;
    localparam longint MWC_APP_WAIT_CYC = MWC_APP_WAIT_S * MWC_CLK_HZ;

    // Command kinds
    typedef enum logic [2:0] {
        MWC_K_STORE = 3'h0,
        MWC_K_FILL = 3'h1,
        MWC_K_EXEC = 3'h2,
        MWC_K_CALL = 3'h3,
        MWC_K_RESET = 3'h4
    } mwc_kind_t;

    // Width of the value to be replicated into fill_word
    typedef enum logic [1:0] {
        MWC_W8 = 2'h0,
        MWC_W16 = 2'h1,
        MWC_W32 = 2'h2
    } mwc_width_t;

    // One user request
    typedef struct packed {
        mwc_kind_t kind;
        mwc_width_t fill_w; // Pattern width for fill
        logic to_flash; // Target region is flash
        logic erased; // Caller vouches the sectors are erased
        logic [31:0] base_addr_param; // Start, jump or call address
        logic [31:0] length_param; // Byte count
        logic [31:0] word; // fill_word or first_arg_reg value
        logic [31:0] stack; // Stack pointer
        logic [31:0] mem_id; // Memory identifier
    } mwc_req_t;

    // Outcome handed back to the user
    typedef struct packed {
        logic local_reject; // Refused here, nothing sent
        logic [31:0] status; // Status from generic_reply_packet, or bad_argument_status if refused here
    } mwc_rsp_t;
endpackage

//--- bench/mwc_dev_model.sv
// Device model answering framed commands
`timescale 1ns/100ps
module mwc_dev_model
    import mwc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Test controls
    input wire logic slow,
    input wire logic [31:0] ret_val,
    // Command stream in
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    // Reply stream out
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic rx_ready,
    // Last command frame, data bytes seen
    output logic [7:0] cmd [0:21],
    output int dcnt
);
    logic [7:0] fr [0:21]; // Frame gathered
    logic [7:0] rq [$]; // Reply bytes pending
    logic [31:0] st;
    int idx, left;
    // Gather frames; reply after command or last data
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            idx = 0;
        else if (tx_valid && tx_ready)
        begin
            fr[idx] = tx_byte;
            idx = idx + 1;
            if (idx > 3 && idx == 6 + fr[2])
            begin
                idx = 0;
                if (fr[1] == MWC_FRAME_DATA)
                begin
                    left = left - fr[2];
                    dcnt = dcnt + fr[2];
                end
                else
                begin
                    cmd = fr;
                    dcnt = 0;
                    left = fr[6] == MWC_OP_STORE ?
                        {fr[17], fr[16], fr[15], fr[14]} : 0;
                end
                // Wrong count refused; else status answer. Data packets
                // carry no count, so the command's own count is judged
                st = cmd[9] == (cmd[6] == MWC_OP_RESET ? 0 : 3) ?
                    ret_val : MWC_BAD_ARG;
                // Verify, padding and the reset before a jump happen
                // inside the device; only the reply is modelled
                if (left == 0)
                    rq = {rq, 8'h5a, 8'ha4, 8'h0c, 8'h00, 8'h00,
                        8'h00, 8'ha0, 8'h00, 8'h00, 8'h02, st[7:0],
                        st[15:8], st[23:16], st[31:24], cmd[6],
                        8'h00, 8'h00, 8'h00};
            end
        end
    end
    // Ready stalls every other cycle when slow
    always @(posedge ref_clk or negedge nrst)
        if (!nrst)
            tx_ready <= 1'b0;
        else
            tx_ready <= slow ? ~tx_ready : 1'b1;
    // Released line shows the inverse of its last byte
    always @(posedge ref_clk or negedge nrst)
        if (!nrst)
            rx_valid <= 1'b0;
        else if (!rx_valid || rx_ready)
        begin
            rx_valid <= rq.size() > 0;
            rx_byte <= rq.size() > 0 ? rq.pop_front() : ~rx_byte;
        end
endmodule // mwc_dev_model

//--- bench/tb_mwc_host.sv
// Self-checking bench for the memory command host
`timescale 1ns/100ps
module tb_mwc_host;
    import mwc_pkg::*;
    logic ref_clk = 0, nrst = 0, req_valid = 0, wr_valid = 0, slow = 0;
    logic req_ready, wr_ready, done, tx_valid, tx_ready, rx_valid;
    logic rx_ready;
    logic [7:0] tx_byte, rx_byte, wr_data = 8'h00;
    logic [31:0] ret_val = 32'h0;
    logic [7:0] cmd [0:21];
    mwc_req_t req = '0;
    mwc_rsp_t rsp;
    int dcnt, err_total = 0, n_checks = 0, cyc = 0, i;
    always #2.5 ref_clk = ~ref_clk;
    mwc_host #(.APP_WAIT_CYC(20)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rsp(rsp), .done(done), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready));
    mwc_dev_model dev (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
        .ret_val(ret_val), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .cmd(cmd), .dcnt(dcnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end
    // Parameter word n of the last command frame
    function automatic logic [31:0] par(input int n);
        return {cmd[13+4*n], cmd[12+4*n], cmd[11+4*n], cmd[10+4*n]};
    endfunction
    function automatic mwc_req_t mk(mwc_kind_t k, logic [1:0] fe,
        logic [31:0] a, logic [31:0] n, logic [31:0] d);
        mk = '0;
        mk.kind = k;
        {mk.to_flash, mk.erased} = fe;
        mk.base_addr_param = a;
        mk.length_param = n;
        mk.word = d;
        mk.stack = 32'h2000_8000;
    endfunction
    // One request, held until taken, then its outcome judged
    task automatic go(input mwc_req_t r, input logic rj, input logic [31:0] s);
        @(negedge ref_clk);
        req = r;
        req_valid = 1;
        @(posedge ref_clk);
        while (!req_ready) @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 0;
        for (i = 0; i < 5000 && done !== 1'b1; i++) @(negedge ref_clk);
        chk(done, 1);
        chk(rsp.local_reject, rj);
        chk(rsp.status, s);
    endtask
    // Store data bytes, each held until taken
    task automatic feed(input int n);
        for (int j = 0; j < n; j++)
        begin
            @(negedge ref_clk);
            wr_data = 8'h10 + 8'(j);
            wr_valid = 1;
            @(posedge ref_clk);
            while (!wr_ready) @(posedge ref_clk);
        end
        @(negedge ref_clk);
        wr_valid = 0;
    endtask
    task automatic t_store();
        fork
            go(mk(MWC_K_STORE, 2'b00, 32'h2000_0401, 5, 0), 0, 0);
            feed(5);
        join
        chk(dcnt, 5);
        chk({cmd[6], cmd[7], cmd[9]}, 32'h040103);
        go(mk(MWC_K_STORE, 2'b11, 32'h0000_0104, 4, 0), 1,
            MWC_BAD_ARG);
    endtask
    task automatic t_fill();
        logic [31:0] w [3] = '{32'hfe, 32'h5afe, 32'h1234_5678};
        logic [31:0] e [3] = '{32'hfefe_fefe, 32'h5afe_5afe, 32'h1234_5678};
        mwc_req_t r;
        for (int k = 0; k < 3; k++)
        begin
            r = mk(MWC_K_FILL, 2'b11, 32'h7000, 32'h800, w[k]);
            r.fill_w = mwc_width_t'(k);
            go(r, 0, 0);
            chk(par(2), e[k]);
            chk({cmd[6], cmd[7]}, 32'h0500);
            chk({cmd[0], cmd[1], cmd[2], cmd[3]}, 32'h5aa4_1000);
        end
        // Last pass is a frame whose CRC is known in advance
        chk({cmd[5], cmd[4]}, 32'h57e4);
        go(mk(MWC_K_FILL, 2'b00, 32'h2000_0000, 6, 0), 1,
            MWC_BAD_ARG);
        go(mk(MWC_K_FILL, 2'b00, 32'h2000_0002, 8, 0), 1,
            MWC_BAD_ARG);
        go(mk(MWC_K_FILL, 2'b10, 32'h7000, 8, 0), 1, MWC_BAD_ARG);
    endtask
    task automatic t_exec_call();
        slow = 1;
        go(mk(MWC_K_EXEC, 2'b00, 32'h1000, 0, 32'hcafe), 0, 0);
        chk(cmd[6], MWC_OP_EXEC);
        chk(par(0), 32'h1000);
        chk(par(1), 32'hcafe);
        chk(par(2), 32'h2000_8000);
        slow = 0;
        ret_val = 32'h1234;
        go(mk(MWC_K_CALL, 2'b00, 32'h2000_0100, 0, 1), 0,
            32'h1234);
        go(mk(MWC_K_CALL, 2'b00, 32'h4000_0000, 0, 1), 1,
            MWC_BAD_ARG);
        ret_val = 0;
        go(mk(MWC_K_RESET, 2'b00, 0, 0, 0), 0, 0);
        chk({cmd[2], cmd[6], cmd[9]}, 32'h040b00);
        chk({cmd[5], cmd[4]}, 32'h466f);
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1;
        t_store();
        t_fill();
        t_exec_call();
        print_verdict();
    end
endmodule // tb_mwc_host
